// File: rtl/dacwp_pkg.sv
package dacwp_pkg;
	// Frame layout: address first, then code, most significant bit first.
	localparam int ADDR_WIDTH  = 5;
	localparam int CODE_WIDTH  = 14;
	localparam int WORD_WIDTH  = ADDR_WIDTH + CODE_WIDTH;
	localparam int CODE_LSB    = 0;
	localparam int ADDR_LSB    = CODE_WIDTH;
	localparam int FIFO_DEPTH  = 8;
	// Host transfer unit length; here it equals the word width, so one unit fills the frame and no bits are padding.
	localparam int HOST_WORD_LENGTH = WORD_WIDTH;
	localparam int HOST_UNITS       = (WORD_WIDTH + HOST_WORD_LENGTH - 1) / HOST_WORD_LENGTH;
	localparam int FRAME_BITS       = HOST_UNITS * HOST_WORD_LENGTH;
	// Link clock divider: serial clock half period in system clocks.
	localparam int SYS_PERIOD_PS = 4000;
	localparam int HALF_DIV      = 8;
	// Least gap between writes, rounded up to system cycles.
	localparam int GAP_NS        = 200;
	localparam int GAP_CYCLES    = (GAP_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	localparam int GAP_W         = 8;
	localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(GAP_CYCLES);
	localparam logic [4:0] BITCNT_RESET = 5'h00;
	localparam logic [3:0] DIV_RESET    = 4'h0;
	localparam logic [3:0] DIV_LAST     = 4'(HALF_DIV - 1);
	localparam logic [4:0] BIT_LAST     = 5'(FRAME_BITS - 1);
	typedef enum logic [1:0] {DACWP_IDLE, DACWP_SETUP, DACWP_SHIFT, DACWP_GAP} dacwp_state_t;
endpackage

// File: rtl/dacwp_fifo.sv
`timescale 1ns/1ps
module dacwp_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 8
)(
	// Clock and control.
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic             enable_in,
	// Fill side.
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side.
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wptr_reg;
	logic [AW-1:0]    rptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Handshake terms from the fill level.
	assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (count_reg != '0);
	assign push          = enable_in && in_valid_in && in_ready_out;
	assign pop           = enable_in && out_valid_out && out_ready_in;
	assign out_data_out  = mem_reg[rptr_reg];

	// Storage is written at the write pointer.
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem_reg[wptr_reg] <= in_data_in;
	end

	// Pointers and fill count.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
			if (pop)
				rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// File: rtl/dacwp_host.sv
`timescale 1ns/1ps
// Contract
// - Host changes data on rising edges
// - One whole 19-bit word per frame
// - Word sent most significant bit first
// - Frame select low throughout the word
// - Frame select returns high between writes
// - Byte hosts send three bytes per frame
// - Longer transfers left-justify the payload
// - Ten-bit hosts may send two words
// - Clock idles low, data valid falling
// - Shift clock travels with the data
// - Five address bits, then fourteen code
// - At least 200 ns between writes
module dacwp_host
	import dacwp_pkg::*;
(
	// System clock, reset and enable.
	input  wire logic                          clk_in,
	input  wire logic                          reset_in,
	input  wire logic                          enable_in,
	// Write requests from user logic.
	input  wire logic                          req_valid_in,
	output logic                               req_ready_out,
	input  wire logic [dacwp_pkg::ADDR_WIDTH-1:0] channel_address_bits_in,
	input  wire logic [dacwp_pkg::CODE_WIDTH-1:0] channel_code_bits_in,
	// Status.
	output logic                               busy_out,
	// Serial pins toward the DAC.
	output logic                               frame_sel_n_out,
	output logic                               sclk_out,
	output logic                               sdata_out
);
	import dacwp_pkg::*;

	logic [WORD_WIDTH-1:0] fifo_data;
	logic                  fifo_valid;
	logic                  fifo_pop;
	dacwp_state_t          state_reg;
	logic [WORD_WIDTH-1:0] shift_reg;
	logic [4:0]            bit_reg;
	logic [3:0]            div_reg;
	logic [GAP_W-1:0]      gap_reg;
	logic                  div_tick;

	// Address packed above the code so it goes out first.
	dacwp_fifo #(
		.WIDTH (WORD_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.enable_in     (enable_in),
		.in_valid_in   (req_valid_in),
		.in_ready_out  (req_ready_out),
		.in_data_in    ({channel_address_bits_in, channel_code_bits_in}),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_data)
	);

	// A word is taken only when the link is idle.
	assign fifo_pop = (state_reg == DACWP_IDLE);
	assign div_tick = (div_reg == DIV_LAST);
	assign busy_out = (state_reg != DACWP_IDLE) || fifo_valid;

	// Divider that paces each serial clock half period.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			div_reg <= DIV_RESET;
		else if (enable_in)
		begin
			if (state_reg == DACWP_IDLE || div_tick)
				div_reg <= DIV_RESET;
			else
				div_reg <= div_reg + 4'h1;
		end
	end

	// Frame sequencer: select, shift the whole word, then hold the gap.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state_reg       <= DACWP_IDLE;
			frame_sel_n_out <= 1'b1;
			sclk_out        <= 1'b0;
			sdata_out       <= 1'b0;
			shift_reg       <= '0;
			bit_reg         <= BITCNT_RESET;
			gap_reg         <= '0;
		end
		else if (enable_in)
		begin
			unique case (state_reg)
				DACWP_IDLE:
				begin
					sclk_out <= 1'b0;
					if (fifo_valid)
					begin
						// Falling select restarts the counter in the DAC.
						frame_sel_n_out <= 1'b0;
						shift_reg       <= fifo_data << 1;
						sdata_out       <= fifo_data[WORD_WIDTH-1];
						bit_reg         <= BITCNT_RESET;
						state_reg       <= DACWP_SETUP;
					end
				end
				DACWP_SETUP:
				begin
					// First bit settles for a half period before the first rise.
					if (div_tick)
					begin
						sclk_out  <= 1'b1;
						state_reg <= DACWP_SHIFT;
					end
				end
				DACWP_SHIFT:
				begin
					if (div_tick)
					begin
						if (sclk_out)
						begin
							// Falling edge: the DAC samples here.
							sclk_out <= 1'b0;
							if (bit_reg == BIT_LAST)
							begin
								// Padding clocks of longer host units carry zeros.
								gap_reg   <= GAP_LOAD;
								state_reg <= DACWP_GAP;
							end
							else
								bit_reg <= bit_reg + 5'h01;
						end
						else
						begin
							// Rising edge: present the next bit.
							sclk_out  <= 1'b1;
							sdata_out <= shift_reg[WORD_WIDTH-1];
							shift_reg <= shift_reg << 1;
						end
					end
				end
				DACWP_GAP:
				begin
					// Select rises one cycle after the last fall so the final bit keeps its hold.
					frame_sel_n_out <= 1'b1;
					// Select stays high for the least spacing.
					if (gap_reg == '0)
						state_reg <= DACWP_IDLE;
					else
						gap_reg <= gap_reg - 1'b1;
				end
			endcase
		end
	end
endmodule

// File: tb/dacwp_dac_model.sv
`timescale 1ns/1ps
module dacwp_dac_model (
	// Serial pins and reset.
	input wire logic rst_n_in,
	input wire logic sel_n_in,
	input wire logic sclk_in,
	input wire logic din_in
);
	logic [13:0] code_reg [32];
	logic [18:0] sh_reg;
	int          cnt = 19;
	// Reset clears every channel; a select fall restarts the count.
	always @(negedge rst_n_in) foreach (code_reg[i]) code_reg[i] = 14'h0000;
	always @(negedge sel_n_in) cnt = 0;
	// Bits enter on the falling clock; clocks past the last bit are ignored.
	always @(negedge sclk_in)
		if (!sel_n_in && cnt < 19)
		begin
			sh_reg = {sh_reg[17:0], din_in};
			cnt++;
			if (cnt == 19) code_reg[sh_reg[18:14]] = sh_reg[13:0];
		end
endmodule

// File: tb/dacwp_host_checker.sv
`timescale 1ns/1ps
module dacwp_host_checker (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_in,
	// Watched outputs.
	input wire logic req_ready_out,
	input wire logic busy_out,
	input wire logic frame_sel_n_out,
	input wire logic sclk_out,
	input wire logic sdata_out
);
	import dacwp_pkg::*;
	logic [7:0] gap_reg;
	logic [4:0] rise_reg;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Deselected cycles, saturating; clock rises seen inside a frame.
	always_ff @(posedge clk_in)
		gap_reg <= reset_in ? 8'hFF : !frame_sel_n_out ? 8'h00 : gap_reg + 8'(gap_reg != 8'hFF);
	always_ff @(posedge clk_in)
		rise_reg <= (reset_in || frame_sel_n_out) ? 5'h00 : rise_reg + 5'($rose(sclk_out));
	chk_data_edge: assert property (!frame_sel_n_out && !$stable(sdata_out)
		|-> $rose(sclk_out) || $fell(frame_sel_n_out)) else $error("data moved off a rise");
	chk_idle_low: assert property (frame_sel_n_out |-> !sclk_out)
		else $error("clock high while idle");
	chk_setup_low: assert property ($fell(frame_sel_n_out) |-> !sclk_out [*4])
		else $error("clock not low at frame start");
	chk_sel_end: assert property ($rose(frame_sel_n_out) |-> !sclk_out && !$past(sclk_out))
		else $error("frame ended with the last fall");
	chk_bit_count: assert property ($rose(frame_sel_n_out) |-> rise_reg == 5'(FRAME_BITS))
		else $error("wrong bit count");
	chk_gap_min: assert property ($fell(frame_sel_n_out) |-> gap_reg >= 8'(GAP_CYCLES))
		else $error("gap too short");
	chk_busy_frame: assert property (!frame_sel_n_out |-> busy_out)
		else $error("frame without busy");
	chk_ready_busy: assert property (!req_ready_out |-> busy_out)
		else $error("refusing while idle");
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import dacwp_pkg::*;
	logic                  clk_in = 0;
	logic                  reset_in = 1;
	logic                  req_valid_in = 0;
	logic                  dac_rst_n = 1;
	logic                  enable_in = 1;
	logic                  stall_on = 0;
	logic [WORD_WIDTH-1:0] exp_q [$];
	logic [ADDR_WIDTH-1:0] addr = 0;
	logic [CODE_WIDTH-1:0] code = 0;
	logic                  req_ready_out, busy_out, frame_sel_n_out, sclk_out, sdata_out;
	logic [CODE_WIDTH-1:0] exp_code [32];
	int                    bad_count = 0;
	int                    n_tests = 0;
	// Host under test and the device it drives.
	dacwp_host u_dut (.clk_in, .reset_in, .enable_in, .req_valid_in, .req_ready_out,
		.channel_address_bits_in(addr), .channel_code_bits_in(code), .busy_out,
		.frame_sel_n_out, .sclk_out, .sdata_out);
	dacwp_dac_model u_dac (.rst_n_in(dac_rst_n), .sel_n_in(frame_sel_n_out),
		.sclk_in(sclk_out), .din_in(sdata_out));
	initial forever #2 clk_in = ~clk_in;
	// Random clock-enable stalls while a queue drains; all state must freeze meanwhile.
	always @(posedge clk_in) #1 enable_in = !stall_on || ($urandom_range(3) != 0);
	// Each finished frame must have delivered the next queued word, 19 bits exactly.
	always @(posedge frame_sel_n_out) if (reset_in === 1'b0) cmp_word();
	// Valid stays up between calls so requests go back to back.
	task automatic send(input logic [4:0] a, input logic [13:0] c);
		addr = a;
		code = c;
		req_valid_in = 1;
		exp_code[a] = c;
		exp_q.push_back({a, c});
		for (int k = 0; k < 3000 && req_ready_out !== 1'b1; k++) @(posedge clk_in) #1;
		@(posedge clk_in) #1;
	endtask
	task automatic cmp_code(input int ch);
		n_tests++;
		if (u_dac.code_reg[ch] !== exp_code[ch])
		begin
			bad_count++;
			$display("[ERR] %0t channel %0d code", $time, ch);
		end
	endtask
	task automatic cmp_word();
		logic [WORD_WIDTH-1:0] w;
		w = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
		n_tests++;
		if (u_dac.cnt != WORD_WIDTH || u_dac.sh_reg !== w)
		begin
			bad_count++;
			$display("[ERR] %0t frame word", $time);
		end
	endtask
	task automatic dac_reset();
		dac_rst_n = 0;
		repeat (3) @(posedge clk_in);
		#1 dac_rst_n = 1;
		foreach (exp_code[i]) exp_code[i] = 14'h0000;
	endtask
	task automatic end_sim();
		$display("mismatches %0d of %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Fill the queue past full, drain it and check, then clear the device and check again.
	initial
	begin
		void'($urandom(62));
		repeat (20) @(posedge clk_in);
		#1 reset_in = 0;
		dac_reset();
		for (int r = 0; r < 2; r++)
		begin
			send(5'h00, 14'h3FFF);
			send(5'h1F, 14'h2001);
			repeat (20) send(5'($urandom), 14'($urandom));
			req_valid_in = 0;
			stall_on = (r == 1);
			for (int k = 0; k < 9000 && busy_out !== 1'b0; k++) @(posedge clk_in) #1;
			stall_on = 0;
			for (int i = 0; i < 32; i++) cmp_code(i);
			dac_reset();
			for (int i = 0; i < 32; i++) cmp_code(i);
		end
		end_sim();
	end
	// A hang counts as a mismatch.
	initial
	begin
		#200000;
		bad_count++;
		end_sim();
	end
endmodule
bind dacwp_host dacwp_host_checker u_chk (.clk_in, .reset_in, .req_ready_out, .busy_out,
	.frame_sel_n_out, .sclk_out, .sdata_out);
